//--- common/ssp_defs.vh
// shared constants of the synthesizer serial programming port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ----------------------------------------
// transfer lengths that select a register
// ----------------------------------------
`define SSP_LEN_CFG        6'd8
`define SSP_LEN_REF        6'd16
`define SSP_LEN_LOOP       6'd24

// ----------------------------------------
// field positions
// ----------------------------------------
`define SSP_CFG_PORT_BIT   1
`define SSP_CFG_DRAIN_BIT  0
`define SSP_REF_CNT_MSB    12
`define SSP_REF_MODE_LSB   13
`define SSP_LOOP_SEL_HI    23
`define SSP_LOOP_SEL_LO    22
`define SSP_LOOP_A_MSB     5
`define SSP_LOOP_N_LSB     6
`define SSP_LOOP_N_MSB     17

// ----------------------------------------
// reset values and output selections
// ----------------------------------------
`define SSP_CFG_RESET      8'h00
`define SSP_REF_RESET      16'h0000
`define SSP_LOOP_RESET     24'h400000
`define SSP_SEL_PORT       2'h0
`define SSP_SEL_DOUT       2'h1
`define SSP_SEL_VCO        2'h2
`define SSP_SEL_REF        2'h3
`define SSP_PRESCALE       7'd64
`define SSP_REF_MIN        13'd5

`endif

//--- hdl/ssp_sync2.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
module ssp_sync2 #(
    parameter [0:0] RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire clk_in,
    input  wire rst_n_in,
    // level in and out
    input  wire level_in,
    output wire level_out
);
    reg meta_reg;
    reg sync_reg;

    // first stage only feeds the second; reset to the pin's idle level so release shows no false edge
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_reg <= RESET_LEVEL;
            sync_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= level_in;
            sync_reg <= meta_reg;
        end
    end

    assign level_out = sync_reg;
endmodule // ssp_sync2

//--- hdl/ssp_serial_port.v
// serial programming port with its register file and output a / b selection
// Operation
// - data sampled on rising shift clock, most significant bit first
// - bit count 8, 16, 24 picks config, reference buffer or divider
// - registers change only on the enable low-to-high edge
// - reference low 13 bits double-buffered; top 3 mode bits act at once
// - divider transfer copies first reference buffer into the second
// - enable pulse with no clocks copies first reference buffer to second
// - no address bits; any register order allowed
// - data out is end of 24.5-stage shifter, changing on falling clock
// - enable high blocks shifting and holds the port initialised
// - no enable change while clock high; resync when enable high, clock low
// - top two divider bits select output a source
// - reference pulse idles low, once per 13-bit count; ratio 1 passes through
// - vco pulse idles low from 12-stage n counter; ratio n*64+a
// - after power-up output a is serial data out
// - port mode drives output a from the port level bit
// - output b pulls low when drain bit is 0, floats when 1
// - power-on reset pulls output b low
`timescale 1ns/10ps
`include "ssp_defs.vh"
module ssp_serial_port #(
    parameter CNT_W = 6
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // serial programming pins (asynchronous)
    input  wire        serial_data_in,
    input  wire        shift_clk_in,
    input  wire        transfer_enable_n_in,
    // reference and rf input edges, one-cycle pulses from same-clock logic
    input  wire        ref_tick_in,
    input  wire        rf_tick_in,
    // output a and open-drain output b
    output reg         output_a_out,
    output wire        output_b_out,
    output wire        output_b_oe_n_out,
    // register contents for the rest of the synthesizer
    output reg  [7:0]  config_byte_out,
    output reg  [15:0] ref_divider_out,
    output reg  [23:0] loop_divider_out,
    output reg  [12:0] ref_count_ratio_out,
    output reg         ref_divided_pulse_out,
    output reg         vco_divided_pulse_out
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire din_s;
    wire sclk_s;
    wire en_n_s;

    // data, clock and enable share one delay, so setup seen at the pins survives the crossing
    ssp_sync2 u_sync_din (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .level_in  (serial_data_in),
        .level_out (din_s)
    );

    ssp_sync2 u_sync_clk (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .level_in  (shift_clk_in),
        .level_out (sclk_s)
    );

    ssp_sync2 #(.RESET_LEVEL(1'b1)) u_sync_enb (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .level_in  (transfer_enable_n_in),
        .level_out (en_n_s)
    );

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    reg sclk_d_reg;
    reg en_n_d_reg;
    reg synced_reg;   // cleared by enable change while clock high

    // enable and clock start idle (high / low) so reset does not look like an edge
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sclk_d_reg <= 1'b0;
            en_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            en_n_d_reg <= en_n_s;
        end
    end

    // edges come from the second synchroniser stage only; the delayed copy adds one cycle
    // hazard: a clock phase shorter than one system cycle can be missed entirely
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    wire en_rise   = en_n_s & ~en_n_d_reg;
    wire en_change = en_n_s ^ en_n_d_reg;

    // ----------------------------------------
    // shifter and bit counter
    // ----------------------------------------
    reg  [23:0]      shift_reg;
    reg  [CNT_W-1:0] count_reg;
    reg              half_stage_reg;   // the extra half stage for data out
    reg              any_clk_reg;

    // resync: an enable change with clock high drops sync until enable high and clock low
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            synced_reg <= 1'b1;
        end else if (en_change && sclk_s) begin
            synced_reg <= 1'b0;
        end else if (en_n_s && !sclk_s) begin
            synced_reg <= 1'b1;
        end
    end

    // shifting only while enable low; enable high clears the count and holds the half stage still
    // limitation: a stream longer than 24 bits keeps only its last 24 bits
    // the count saturates, so a very long stream can never wrap back to 8, 16 or 24
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            shift_reg      <= 24'h000000;
            count_reg      <= {CNT_W{1'b0}};
            half_stage_reg <= 1'b0;
            any_clk_reg    <= 1'b0;
        end else if (en_n_s || !synced_reg) begin
            count_reg   <= {CNT_W{1'b0}};
            any_clk_reg <= 1'b0;
        end else begin
            if (sclk_rise) begin
                shift_reg   <= {shift_reg[22:0], din_s};
                any_clk_reg <= 1'b1;
                if (count_reg != {CNT_W{1'b1}}) begin
                    count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            if (sclk_fall) begin
                half_stage_reg <= shift_reg[23];
            end
        end
    end

    // ----------------------------------------
    // transfer length decode
    // ----------------------------------------
    localparam LOAD_NONE = 2'b00;
    localparam LOAD_CFG  = 2'b01;
    localparam LOAD_REF  = 2'b10;
    localparam LOAD_LOOP = 2'b11;

    // maps the bit count of a finished frame to the register it loads
    function [1:0] load_target;
        input [CNT_W-1:0] cnt;
        begin
            if (cnt == `SSP_LEN_CFG) begin
                load_target = LOAD_CFG;
            end else if (cnt == `SSP_LEN_REF) begin
                load_target = LOAD_REF;
            end else if (cnt == `SSP_LEN_LOOP) begin
                load_target = LOAD_LOOP;
            end else begin
                load_target = LOAD_NONE;
            end
        end
    endfunction

    // ----------------------------------------
    // register loads on the enable rising edge
    // ----------------------------------------
    // an enable edge seen while the clock is high is a framing fault and loads nothing
    wire commit = en_rise & synced_reg & ~sclk_s;

    // one-cycle commit; loads use the count and shifter from before enable rose
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            config_byte_out     <= `SSP_CFG_RESET;
            ref_divider_out     <= `SSP_REF_RESET;
            loop_divider_out    <= `SSP_LOOP_RESET;
            ref_count_ratio_out <= 13'h0000;
        end else if (commit) begin
            if (!any_clk_reg) begin
                ref_count_ratio_out <= ref_divider_out[`SSP_REF_CNT_MSB:0];
            end else begin
                case (load_target(count_reg))
                    LOAD_CFG: begin
                        config_byte_out <= shift_reg[7:0];
                    end
                    LOAD_REF: begin
                        ref_divider_out <= shift_reg[15:0];
                    end
                    LOAD_LOOP: begin
                        loop_divider_out    <= shift_reg;
                        ref_count_ratio_out <= ref_divider_out[`SSP_REF_CNT_MSB:0];
                    end
                    default: begin
                        // any other count loads nothing
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // shared counter arithmetic
    // ----------------------------------------
    // true when one more tick reaches the ratio; a ratio of 0 wraps on every tick
    function wrap_due;
        input [18:0] cnt;
        input [18:0] ratio;
        begin
            wrap_due = (cnt + 19'h00001) >= ratio;
        end
    endfunction

    // ----------------------------------------
    // reference divider
    // ----------------------------------------
    reg [12:0] ref_cnt_reg;

    // counts reference ticks; ratio 1 passes the tick through, hazard: ratios 2..4 treated as counts
    // trade-off: unsupported ratios are counted rather than blocked, which keeps the path small
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ref_cnt_reg           <= 13'h0000;
            ref_divided_pulse_out <= 1'b0;
        end else if (ref_count_ratio_out == 13'h0001) begin
            ref_cnt_reg           <= 13'h0000;
            ref_divided_pulse_out <= ref_tick_in;
        end else if (ref_tick_in) begin
            if (wrap_due({6'h00, ref_cnt_reg}, {6'h00, ref_count_ratio_out})) begin
                ref_cnt_reg           <= 13'h0000;
                ref_divided_pulse_out <= 1'b1;
            end else begin
                ref_cnt_reg           <= ref_cnt_reg + 13'h0001;
                ref_divided_pulse_out <= 1'b0;
            end
        end else begin
            ref_divided_pulse_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // loop divider: total ratio n*64+a
    // ----------------------------------------
    wire [11:0] n_val = loop_divider_out[`SSP_LOOP_N_MSB:`SSP_LOOP_N_LSB];
    wire [5:0]  a_val = loop_divider_out[`SSP_LOOP_A_MSB:0];
    wire [18:0] vco_ratio = {n_val, 7'h00} - {1'b0, n_val, 6'h00} + {13'h0000, a_val};
    reg  [18:0] vco_cnt_reg;

    // one counter stands for prescaler, a and n counters; needs n >= a from the host
    // limitation: only the overall ratio is kept, not the edge timing of a swallow scheme
    // a new ratio takes effect at the next wrap or sooner, never mid-way back to zero
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            vco_cnt_reg           <= 19'h00000;
            vco_divided_pulse_out <= 1'b0;
        end else if (rf_tick_in) begin
            if (wrap_due(vco_cnt_reg, vco_ratio)) begin
                vco_cnt_reg           <= 19'h00000;
                vco_divided_pulse_out <= 1'b1;
            end else begin
                vco_cnt_reg           <= vco_cnt_reg + 19'h00001;
                vco_divided_pulse_out <= 1'b0;
            end
        end else begin
            vco_divided_pulse_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // output a selection and output b
    // ----------------------------------------
    wire [1:0] out_sel = {loop_divider_out[`SSP_LOOP_SEL_HI], loop_divider_out[`SSP_LOOP_SEL_LO]};

    reg out_a_next;

    // source for output a, picked by the top two divider bits
    always @* begin
        case (out_sel)
            `SSP_SEL_REF:  out_a_next = ref_divided_pulse_out;
            `SSP_SEL_VCO:  out_a_next = vco_divided_pulse_out;
            `SSP_SEL_DOUT: out_a_next = half_stage_reg;
            `SSP_SEL_PORT: out_a_next = config_byte_out[`SSP_CFG_PORT_BIT];
            default:       out_a_next = 1'b0;
        endcase
    end

    // registered so output a is glitch free; it lags its source by one cycle
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            output_a_out <= 1'b0;
        end else begin
            output_a_out <= out_a_next;
        end
    end

    // open drain: enable low pulls the pin low; reset value of drain bit is 0
    // the pin is never driven high; an outside pull-up supplies the high level
    assign output_b_out      = 1'b0;
    assign output_b_oe_n_out = config_byte_out[`SSP_CFG_DRAIN_BIT];
endmodule // ssp_serial_port

//--- bench/ssp_port_monitor.sv
// assertion checker for the serial programming port
`timescale 1ns/10ps
module ssp_port_monitor (
    // clock, reset and inputs
    input wire        clk_in,
    input wire        rst_n_in,
    input wire        transfer_enable_n_in,
    input wire        ref_tick_in,
    input wire        rf_tick_in,
    // outputs
    input wire        output_a_out,
    input wire        output_b_out,
    input wire        output_b_oe_n_out,
    input wire [7:0]  config_byte_out,
    input wire [23:0] loop_divider_out,
    input wire [12:0] ref_count_ratio_out,
    input wire        ref_divided_pulse_out,
    input wire        vco_divided_pulse_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // two settled cycles of port mode, so output a has had time to follow
    sequence s_port_mode;
        loop_divider_out[23:22] == 2'h0 ##1 loop_divider_out[23:22] == 2'h0;
    endsequence
    property p_reset_values;
        @(posedge clk_in) disable iff (1'b0) !rst_n_in |=> config_byte_out == 8'h00 && loop_divider_out == 24'h400000 && !output_b_oe_n_out;
    endproperty
    property p_drain;
        output_b_out == 1'b0 && output_b_oe_n_out == config_byte_out[0];
    endproperty
    property p_cfg_commit;
        !$stable(config_byte_out) |-> transfer_enable_n_in && $past(transfer_enable_n_in);
    endproperty
    property p_ratio_commit;
        !$stable(ref_count_ratio_out) |-> transfer_enable_n_in && $past(transfer_enable_n_in);
    endproperty
    property p_port_level;
        s_port_mode |-> output_a_out == $past(config_byte_out[1]);
    endproperty
    property p_ratio_one;
        ref_count_ratio_out == 13'h0001 && ref_tick_in |=> ref_divided_pulse_out;
    endproperty
    property p_ref_pulse;
        ref_divided_pulse_out |-> $past(ref_tick_in);
    endproperty
    property p_vco_pulse;
        vco_divided_pulse_out |-> $past(rf_tick_in);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
    a_drain: assert property (p_drain) else $error("output b does not follow drain bit");
    a_cfg_commit: assert property (p_cfg_commit) else $error("config changed while enabled");
    a_ratio_commit: assert property (p_ratio_commit) else $error("ratio changed while enabled");
    a_port_level: assert property (p_port_level) else $error("port level wrong");
    a_ratio_one: assert property (p_ratio_one) else $error("ratio one not passed through");
    a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse without tick");
    a_vco_pulse: assert property (p_vco_pulse) else $error("vco pulse without tick");
endmodule // ssp_port_monitor
bind ssp_serial_port ssp_port_monitor ssp_port_monitor_inst (.clk_in, .rst_n_in, .transfer_enable_n_in,
    .ref_tick_in, .rf_tick_in, .output_a_out, .output_b_out, .output_b_oe_n_out, .config_byte_out,
    .loop_divider_out, .ref_count_ratio_out, .ref_divided_pulse_out, .vco_divided_pulse_out);

//--- bench/ssp_host_model.sv
// host model driving the serial programming pins
`timescale 1ns/10ps
module ssp_host_model (
    // clock and serial pins
    input  wire clk_in,
    output reg  serial_data_out,
    output reg  shift_clk_out,
    output reg  transfer_enable_n_out
);
    integer i;
    // idle: enable high, clock low, which also keeps power-on reset safe
    initial begin
        serial_data_out       = 1'b0;
        shift_clk_out         = 1'b0;
        transfer_enable_n_out = 1'b1;
    end
    // one framed word, msb first; a count of zero gives a bare enable pulse
    task xfer(input [23:0] w, input integer n);
        begin
            @(posedge clk_in) transfer_enable_n_out <= 1'b0; // clock is low
            for (i = n - 1; i >= 0; i = i - 1) begin
                repeat (4) @(posedge clk_in);
                serial_data_out <= w[i];
                repeat (4) @(posedge clk_in);
                shift_clk_out <= 1'b1; // phases of 4+ cycles so the synced edge is seen
                repeat (5) @(posedge clk_in);
                shift_clk_out <= 1'b0;
            end
            repeat (5) @(posedge clk_in);
            transfer_enable_n_out <= 1'b1; // commit, clock low
            repeat (4) @(posedge clk_in);
            serial_data_out <= ~serial_data_out; // no stale bit left on an idle line
            repeat (12) @(posedge clk_in);
        end
    endtask
endmodule // ssp_host_model

//--- bench/ssp_testbench.sv
// self-checking testbench of the serial programming port
`timescale 1ns/10ps
module testbench;
    reg         clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         ref_tick = 1'b0;
    reg         rf_tick = 1'b0;
    wire        sdata, sclk, enb_n, out_a, out_b, oe_n, ref_pulse, vco_pulse;
    wire [7:0]  cfg;
    wire [15:0] rdiv;
    wire [23:0] ldiv;
    wire [12:0] ratio;
    wire [60:0] cur = {cfg, rdiv, ldiv, ratio};
    reg  [60:0] prev = 61'h0;
    reg  [60:0] ex = {8'h00, 16'h0000, 24'h400000, 13'h0000};
    reg  [60:0] q[$];
    reg  [23:0] w;
    integer     seed = 26363, err_count = 0, n_tests = 0, t;
    integer     lens[0:9] = '{8, 16, 0, 24, 8, 12, 24, 16, 24, 8};
    // 100 MHz clock and random tick streams
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        ref_tick <= 1'($random(seed));
        rf_tick <= 1'($random(seed));
    end
    ssp_host_model ssp_host_model_inst (.clk_in(clk_in), .serial_data_out(sdata), .shift_clk_out(sclk),
        .transfer_enable_n_out(enb_n));
    ssp_serial_port ssp_serial_port_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_data_in(sdata),
        .shift_clk_in(sclk), .transfer_enable_n_in(enb_n), .ref_tick_in(ref_tick), .rf_tick_in(rf_tick),
        .output_a_out(out_a), .output_b_out(out_b), .output_b_oe_n_out(oe_n), .config_byte_out(cfg),
        .ref_divider_out(rdiv), .loop_divider_out(ldiv), .ref_count_ratio_out(ratio),
        .ref_divided_pulse_out(ref_pulse), .vco_divided_pulse_out(vco_pulse));
    task chk(input [60:0] got, input [60:0] exp, input [255:0] msg);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: %0s", $time, msg);
            end
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // every visible register update takes the oldest expected note
    always @(posedge clk_in) begin
        if (rst_n_in && cur !== prev)
            chk(cur, q.size() > 0 ? q.pop_front() : ~cur, "register update");
        prev <= cur;
    end
    // a hang is cut off well past the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count = err_count + 1;
        test_done;
    end
    // lengths cover each register, a bare enable pulse and a refused count of 12
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(cur, ex, "reset values");
        chk({60'h0, oe_n}, 61'h0, "output b after reset");
        for (t = 0; t < 10; t = t + 1) begin
            w = 24'($random(seed));
            if (t == 1)
                w[12:0] = 13'h0001;
            if (t == 3)
                w[23:22] = 2'h0;
            if (lens[t] == 24)
                w[17] = 1'b1; // n counter stays above the a counter
            case (lens[t])
                8: ex[60:53] = w[7:0];
                16: ex[52:37] = w[15:0];
                24: ex = {ex[60:37], w, ex[49:37]};
                0: ex[12:0] = ex[49:37];
                default: ex = ex;
            endcase
            if (q.size() == 0 ? ex !== prev : ex !== q[$])
                q.push_back(ex);
            ssp_host_model_inst.xfer(w, lens[t]);
            chk({60'h0, oe_n}, {60'h0, ex[53]}, "output b level");
            if (t == 1)
                chk({60'h0, out_a}, {60'h0, ex[60]}, "data out after 24 bits");
            if (ex[36:35] == 2'h0)
                chk({60'h0, out_a}, {60'h0, ex[54]}, "port level");
            $display("test %0d done", t);
        end
        chk(61'(q.size()), 61'h0, "pending updates");
        test_done;
    end
endmodule // testbench
